// >>> src/conv_bank_consts.vh
// Offsets, field positions, reset values and timing counts of the converter config bank
`ifndef CONV_BANK_CONSTS_VH
`define CONV_BANK_CONSTS_VH

// Register offsets (byte addresses = 4 * index)
`define OFS_DRV_BLANK 8'h2b
`define OFS_STARTUP 8'h2c
`define OFS_SPEEDUP 8'h2d
`define OFS_MIRROR_PD 8'h2e
`define OFS_FUSE_SETUP 8'h2f
`define OFS_RESET_TRIG 8'h30
`define OFS_KEY_FIRST 8'h31
`define OFS_KEY_SECOND 8'h32
`define OFS_KEY_THIRD 8'h33
`define OFS_MASK_FIRST 8'h3a
`define OFS_MASK_SECOND 8'h3b
`define OFS_ALARM_IN 8'h3c
`define OFS_FUSE_STAT 8'h3d

// Reset values
`define RST_DRV_BLANK 8'h00
`define RST_STARTUP 8'h30
`define RST_SPEEDUP 8'h00
`define RST_MIRROR_PD 8'h00
`define RST_FUSE_SETUP 8'h00
`define RST_MASK 8'h00

// Keys
`define KEY_SOFT_RESET 8'haa
`define KEY_UNLOCK_1 8'haf
`define KEY_UNLOCK_2 8'hfa
`define KEY_UNLOCK_3 8'h55

// Field positions
`define F_STRENGTH_HI 7
`define F_STRENGTH_LO 6
`define F_BLANK_HI 5
`define F_BLANK_LO 4
`define F_SWITCH_HI 3
`define F_SWITCH_LO 0
`define F_FORCE_UP 7
`define F_FORCE_DOWN 6
`define F_RATE_HI 5
`define F_RATE_LO 4
`define F_BYPASS_RAMP 3
`define F_DEAD_ZONE 2
`define F_SPUP_OFF 7
`define F_SPUP_FILTER 6
`define F_RING_OFF 5
`define F_SPUP_DAC_HI 4
`define F_SPUP_DAC_LO 0
`define F_HIGH_OFF 2
`define F_MID_OFF 1
`define F_NEG_OFF 0
`define F_RD_CUR_HI 6
`define F_RD_CUR_LO 5
`define F_WR_CUR_HI 4
`define F_WR_CUR_LO 3
`define F_PULSE_HI 2
`define F_PULSE_LO 0

// Soft reset: 16 cycles of 12 MHz (1334 ns) as 100 ns core cycles, rounded up
`define SOFT_RST_CYC 5'h0e

`endif

// >>> src/converter_fuse_reset_config_bank.v
// Converter, fuse and reset configuration register bank with Avalon-MM slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "conv_bank_consts.vh"

module converter_fuse_reset_config_bank (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // Avalon-MM slave
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Raw alarm status from the analog side
    input wire [7:0] first_alarm_status_i,
    input wire [7:0] second_alarm_status_i,
    // Fuse programming request and done
    input wire fuse_burn_req_i,
    input wire fuse_burn_done_i,
    // Converter trims
    output reg [1:0] predriver_strength_o,
    output reg [1:0] blanking_select_o,
    output reg [3:0] power_switch_disable_o,
    output reg force_step_up_o,
    output reg force_step_down_o,
    output reg [1:0] switching_frequency_select_o,
    output reg bypass_soft_ramp_o,
    output reg dead_zone_large_o,
    output reg speedup_off_o,
    output reg speedup_filter_on_o,
    output reg ringing_guard_off_o,
    output reg [4:0] speedup_current_code_o,
    // Mirror rail power downs
    output reg high_mirror_rail_off_o,
    output reg middle_mirror_rail_off_o,
    output reg negative_rail_off_o,
    // Fuse setup
    output reg [1:0] fuse_read_current_o,
    output reg [1:0] fuse_write_current_o,
    output reg [2:0] fuse_burn_pulse_length_o,
    output reg fuse_burn_enable_o,
    // Soft reset and masked alarms
    output reg soft_reset_o,
    output reg [7:0] first_alarm_status_o,
    output reg [7:0] second_alarm_status_o
);

    // ------------------------------------------------------------
    // Unlock sequencer states
    // ------------------------------------------------------------
    localparam [1:0] UNL_IDLE = 2'b00;
    localparam [1:0] UNL_GOT1 = 2'b01;
    localparam [1:0] UNL_GOT2 = 2'b10;
    localparam [1:0] UNL_OPEN = 2'b11;

    reg [7:0] drv_blank_reg;
    reg [7:0] startup_reg;
    reg [7:0] speedup_reg;
    reg [7:0] mirror_pd_reg;
    reg [7:0] fuse_setup_reg;
    reg [7:0] mask_first_reg;
    reg [7:0] mask_second_reg;
    reg [4:0] rst_cnt_reg;
    reg [1:0] unl_state_reg;
    reg [1:0] unl_state_next;
    reg ack_reg;
    reg [7:0] rd_data_next;

    // Alarm inputs come from outside the clock: three-stage sync
    reg [7:0] al0_s1_reg;
    reg [7:0] al0_s2_reg;
    reg [7:0] al0_s3_reg;
    reg [7:0] al1_s1_reg;
    reg [7:0] al1_s2_reg;
    reg [7:0] al1_s3_reg;
    reg [7:0] al0_stable_reg;
    reg [7:0] al1_stable_reg;
    reg [2:0] burn_sync_reg;
    reg [2:0] done_sync_reg;
    reg burn_stable_reg;
    reg done_stable_reg;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire [5:0] word_index = avs_address_i[7:2];
    wire [7:0] wdata = avs_writedata_i[7:0];
    wire wr_fire = avs_write_i && ack_reg && avs_byteenable_i[0];
    wire rd_fire = avs_read_i && ack_reg;

    // One wait cycle per access, then acknowledge
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && !ack_reg) begin
            ack_reg <= 1'b1;
            avs_waitrequest_o <= 1'b0;
        end else begin
            ack_reg <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end
    end

    function is_at;
        input [5:0] idx;
        input [7:0] ofs;
        begin
            is_at = (idx == ofs[5:0]);
        end
    endfunction

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i || soft_reset_o) begin
            drv_blank_reg <= `RST_DRV_BLANK;
            startup_reg <= `RST_STARTUP;
            speedup_reg <= `RST_SPEEDUP;
            mirror_pd_reg <= `RST_MIRROR_PD;
            fuse_setup_reg <= `RST_FUSE_SETUP;
            mask_first_reg <= `RST_MASK;
            mask_second_reg <= `RST_MASK;
        end else if (wr_fire) begin
            if (is_at(word_index, `OFS_DRV_BLANK)) begin
                drv_blank_reg <= wdata;
            end else if (is_at(word_index, `OFS_STARTUP)) begin
                startup_reg <= wdata;
            end else if (is_at(word_index, `OFS_SPEEDUP)) begin
                speedup_reg <= wdata;
            end else if (is_at(word_index, `OFS_MIRROR_PD)) begin
                mirror_pd_reg <= wdata;
            end else if (is_at(word_index, `OFS_FUSE_SETUP)) begin
                fuse_setup_reg <= wdata;
            end else if (is_at(word_index, `OFS_MASK_FIRST)) begin
                mask_first_reg <= wdata;
            end else if (is_at(word_index, `OFS_MASK_SECOND)) begin
                mask_second_reg <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Keyed soft reset
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rst_cnt_reg <= 5'h00;
            soft_reset_o <= 1'b0;
        end else if (rst_cnt_reg != 5'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 5'h01;
            soft_reset_o <= (rst_cnt_reg != 5'h01);
        end else if (wr_fire && is_at(word_index, `OFS_RESET_TRIG) && wdata == `KEY_SOFT_RESET) begin
            rst_cnt_reg <= `SOFT_RST_CYC;
            soft_reset_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Fuse unlock sequence
    // ------------------------------------------------------------
    always @* begin
        unl_state_next = unl_state_reg;
        if (wr_fire) begin
            case (unl_state_reg)
                UNL_IDLE: begin
                    if (is_at(word_index, `OFS_KEY_FIRST) && wdata == `KEY_UNLOCK_1) begin
                        unl_state_next = UNL_GOT1;
                    end
                end
                UNL_GOT1: begin
                    if (is_at(word_index, `OFS_KEY_SECOND) && wdata == `KEY_UNLOCK_2) begin
                        unl_state_next = UNL_GOT2;
                    end else begin
                        unl_state_next = UNL_IDLE;
                    end
                end
                UNL_GOT2: begin
                    if (is_at(word_index, `OFS_KEY_THIRD) && wdata == `KEY_UNLOCK_3) begin
                        unl_state_next = UNL_OPEN;
                    end else begin
                        unl_state_next = UNL_IDLE;
                    end
                end
                default: begin
                    unl_state_next = UNL_IDLE;
                end
            endcase
        end else if (unl_state_reg == UNL_OPEN && done_stable_reg) begin
            unl_state_next = UNL_IDLE;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i || soft_reset_o) begin
            unl_state_reg <= UNL_IDLE;
        end else begin
            unl_state_reg <= unl_state_next;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers, change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            al0_s1_reg <= 8'h00;
            al0_s2_reg <= 8'h00;
            al0_s3_reg <= 8'h00;
            al1_s1_reg <= 8'h00;
            al1_s2_reg <= 8'h00;
            al1_s3_reg <= 8'h00;
            burn_sync_reg <= 3'h0;
            done_sync_reg <= 3'h0;
        end else begin
            al0_s1_reg <= first_alarm_status_i;
            al0_s2_reg <= al0_s1_reg;
            al0_s3_reg <= al0_s2_reg;
            al1_s1_reg <= second_alarm_status_i;
            al1_s2_reg <= al1_s1_reg;
            al1_s3_reg <= al1_s2_reg;
            burn_sync_reg <= {burn_sync_reg[1:0], fuse_burn_req_i};
            done_sync_reg <= {done_sync_reg[1:0], fuse_burn_done_i};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_alarm_bit
            always @(posedge core_clk_i) begin
                if (rst_i) begin
                    al0_stable_reg[gi] <= 1'b0;
                    al1_stable_reg[gi] <= 1'b0;
                end else begin
                    if (al0_s2_reg[gi] == al0_s3_reg[gi]) begin
                        al0_stable_reg[gi] <= al0_s3_reg[gi];
                    end
                    if (al1_s2_reg[gi] == al1_s3_reg[gi]) begin
                        al1_stable_reg[gi] <= al1_s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            burn_stable_reg <= 1'b0;
            done_stable_reg <= 1'b0;
        end else begin
            if (burn_sync_reg[1] == burn_sync_reg[2]) begin
                burn_stable_reg <= burn_sync_reg[2];
            end
            if (done_sync_reg[1] == done_sync_reg[2]) begin
                done_stable_reg <= done_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            predriver_strength_o <= 2'h0;
            blanking_select_o <= 2'h0;
            power_switch_disable_o <= 4'h0;
            force_step_up_o <= 1'b0;
            force_step_down_o <= 1'b0;
            switching_frequency_select_o <= 2'h3;
            bypass_soft_ramp_o <= 1'b0;
            dead_zone_large_o <= 1'b0;
            speedup_off_o <= 1'b0;
            speedup_filter_on_o <= 1'b0;
            ringing_guard_off_o <= 1'b0;
            speedup_current_code_o <= 5'h00;
            high_mirror_rail_off_o <= 1'b0;
            middle_mirror_rail_off_o <= 1'b0;
            negative_rail_off_o <= 1'b0;
            fuse_read_current_o <= 2'h0;
            fuse_write_current_o <= 2'h0;
            fuse_burn_pulse_length_o <= 3'h0;
            fuse_burn_enable_o <= 1'b0;
            first_alarm_status_o <= 8'h00;
            second_alarm_status_o <= 8'h00;
        end else begin
            predriver_strength_o <= drv_blank_reg[`F_STRENGTH_HI:`F_STRENGTH_LO];
            blanking_select_o <= drv_blank_reg[`F_BLANK_HI:`F_BLANK_LO];
            power_switch_disable_o <= drv_blank_reg[`F_SWITCH_HI:`F_SWITCH_LO];
            force_step_up_o <= startup_reg[`F_FORCE_UP];
            force_step_down_o <= startup_reg[`F_FORCE_DOWN];
            switching_frequency_select_o <= startup_reg[`F_RATE_HI:`F_RATE_LO];
            bypass_soft_ramp_o <= startup_reg[`F_BYPASS_RAMP];
            dead_zone_large_o <= startup_reg[`F_DEAD_ZONE];
            speedup_off_o <= speedup_reg[`F_SPUP_OFF];
            speedup_filter_on_o <= speedup_reg[`F_SPUP_FILTER];
            ringing_guard_off_o <= speedup_reg[`F_RING_OFF];
            speedup_current_code_o <= speedup_reg[`F_SPUP_DAC_HI:`F_SPUP_DAC_LO];
            high_mirror_rail_off_o <= mirror_pd_reg[`F_HIGH_OFF];
            middle_mirror_rail_off_o <= mirror_pd_reg[`F_MID_OFF];
            negative_rail_off_o <= mirror_pd_reg[`F_NEG_OFF];
            fuse_read_current_o <= fuse_setup_reg[`F_RD_CUR_HI:`F_RD_CUR_LO];
            fuse_write_current_o <= fuse_setup_reg[`F_WR_CUR_HI:`F_WR_CUR_LO];
            fuse_burn_pulse_length_o <= fuse_setup_reg[`F_PULSE_HI:`F_PULSE_LO];
            fuse_burn_enable_o <= (unl_state_reg == UNL_OPEN) && burn_stable_reg;
            first_alarm_status_o <= al0_stable_reg & ~mask_first_reg;
            second_alarm_status_o <= al1_stable_reg & ~mask_second_reg;
        end
    end

    // ------------------------------------------------------------
    // Read mux; key registers read zero, unmapped read zero
    // ------------------------------------------------------------
    always @* begin
        rd_data_next = 8'h00;
        if (is_at(word_index, `OFS_DRV_BLANK)) begin
            rd_data_next = drv_blank_reg;
        end else if (is_at(word_index, `OFS_STARTUP)) begin
            rd_data_next = startup_reg;
        end else if (is_at(word_index, `OFS_SPEEDUP)) begin
            rd_data_next = speedup_reg;
        end else if (is_at(word_index, `OFS_MIRROR_PD)) begin
            rd_data_next = mirror_pd_reg;
        end else if (is_at(word_index, `OFS_FUSE_SETUP)) begin
            rd_data_next = fuse_setup_reg;
        end else if (is_at(word_index, `OFS_RESET_TRIG)) begin
            rd_data_next = {7'h00, soft_reset_o};
        end else if (is_at(word_index, `OFS_MASK_FIRST)) begin
            rd_data_next = mask_first_reg;
        end else if (is_at(word_index, `OFS_MASK_SECOND)) begin
            rd_data_next = mask_second_reg;
        end else if (is_at(word_index, `OFS_ALARM_IN)) begin
            rd_data_next = al0_stable_reg;
        end else if (is_at(word_index, `OFS_FUSE_STAT)) begin
            rd_data_next = {6'h00, unl_state_reg};
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_reg) begin
            avs_readdata_o <= {24'h00_0000, rd_data_next};
        end
    end

endmodule // converter_fuse_reset_config_bank
`default_nettype wire

// >>> test/conv_bank_sva.sv
// Checker for bus timing, trims, soft reset, unlock gating and a quiet first alarm output with no first alarm in
`timescale 1ns/100ps
`default_nettype none
module conv_bank_sva (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Watched functions
    input wire logic [1:0] predriver_strength_o,
    input wire logic [1:0] switching_frequency_select_o,
    input wire logic [4:0] speedup_current_code_o,
    input wire logic high_mirror_rail_off_o,
    input wire logic fuse_burn_enable_o,
    input wire logic soft_reset_o,
    input wire logic [7:0] first_alarm_status_i,
    input wire logic [7:0] first_alarm_status_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] hi_cnt_reg;
    logic [7:0] last_wdata_reg;
    // ----
    // Helper logic
    // ----
    always @(posedge core_clk_i) begin
        if (rst_i || !soft_reset_o) begin
            hi_cnt_reg <= 8'h00;
        end else begin
            hi_cnt_reg <= hi_cnt_reg + 8'h01;
        end
        if (avs_write_i && !avs_waitrequest_o) begin
            last_wdata_reg <= avs_writedata_i[7:0];
        end
    end
    sequence s_commit(logic [7:0] a);
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == a && !soft_reset_o;
    endsequence
    sequence s_key_write;
        s_commit(8'hc0) ##0 avs_writedata_i[7:0] == 8'haa;
    endsequence
    // ----
    // Assertions
    // ----
    a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest not low one cycle after request");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_read_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_strength_write: assert property (s_commit(8'hac) |-> ##2 predriver_strength_o == last_wdata_reg[7:6])
        else $error("predriver strength does not follow write");
    a_rate_write: assert property (s_commit(8'hb0) |-> ##2 switching_frequency_select_o == last_wdata_reg[5:4])
        else $error("switching frequency does not follow write");
    a_speed_code: assert property (s_commit(8'hb4) |-> ##2 speedup_current_code_o == last_wdata_reg[4:0])
        else $error("speed-up code does not follow write");
    a_rail_write: assert property (s_commit(8'hb8) |-> ##2 high_mirror_rail_off_o == last_wdata_reg[2])
        else $error("high rail off does not follow write");
    a_no_enable_ignored: assert property (avs_write_i && !avs_waitrequest_o && !avs_byteenable_i[0]
        && avs_address_i == 8'hb0 |-> ##2 $stable(switching_frequency_select_o))
        else $error("write without byte enable changed a field");
    a_key_starts: assert property (s_key_write |-> ##[1:4] soft_reset_o)
        else $error("reset key did not start soft reset");
    a_soft_len: assert property ($fell(soft_reset_o) |-> hi_cnt_reg == 8'h0e)
        else $error("soft reset length wrong");
    a_nonkey_quiet: assert property (s_commit(8'hc0) ##0 avs_writedata_i[7:0] != 8'haa |=> !soft_reset_o [*4])
        else $error("non-key write started soft reset");
    a_burn_locked: assert property (soft_reset_o [*3] |-> !fuse_burn_enable_o)
        else $error("burn enabled during soft reset");
    a_alarm_quiet: assert property ((first_alarm_status_i == 8'h00) [*8] |-> first_alarm_status_o == 8'h00)
        else $error("alarm out set with no alarm in");
endmodule // conv_bank_sva

bind converter_fuse_reset_config_bank conv_bank_sva u_conv_bank_sva (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .predriver_strength_o(predriver_strength_o), .switching_frequency_select_o(switching_frequency_select_o),
    .speedup_current_code_o(speedup_current_code_o), .high_mirror_rail_off_o(high_mirror_rail_off_o),
    .fuse_burn_enable_o(fuse_burn_enable_o), .soft_reset_o(soft_reset_o),
    .first_alarm_status_i(first_alarm_status_i), .first_alarm_status_o(first_alarm_status_o));
`default_nettype wire

// >>> test/converter_fuse_reset_config_bank_test.sv
// Self-checking bench for the converter config bank
`timescale 1ns/100ps
`default_nettype none
module converter_fuse_reset_config_bank_test;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [7:0] first_alarm_status_i = 8'h00;
    logic [7:0] second_alarm_status_i = 8'h00;
    logic fuse_burn_req_i = 1'b0;
    logic fuse_burn_done_i = 1'b0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    wire [7:0] out_2b, out_2d, al0_o, al1_o;
    wire [5:0] out_2c;
    wire [2:0] out_2e;
    wire [6:0] out_2f;
    wire burn_en, soft_rst;
    int err_count = 0;
    int samples_checked = 0;
    integer seed = 32'haaa11d60;
    int mdl[64];
    int n, k;
    logic [31:0] r, r2;
    logic [5:0] regs[13] = '{6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33, 6'h3a, 6'h3b, 6'h20, 6'h3d};
    logic [5:0] wregs[7] = '{6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h2f, 6'h3a, 6'h3b};

    converter_fuse_reset_config_bank u_converter_fuse_reset_config_bank (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .first_alarm_status_i(first_alarm_status_i), .second_alarm_status_i(second_alarm_status_i),
        .fuse_burn_req_i(fuse_burn_req_i), .fuse_burn_done_i(fuse_burn_done_i),
        .predriver_strength_o(out_2b[7:6]), .blanking_select_o(out_2b[5:4]), .power_switch_disable_o(out_2b[3:0]),
        .force_step_up_o(out_2c[5]), .force_step_down_o(out_2c[4]), .switching_frequency_select_o(out_2c[3:2]),
        .bypass_soft_ramp_o(out_2c[1]), .dead_zone_large_o(out_2c[0]), .speedup_off_o(out_2d[7]),
        .speedup_filter_on_o(out_2d[6]), .ringing_guard_off_o(out_2d[5]), .speedup_current_code_o(out_2d[4:0]),
        .high_mirror_rail_off_o(out_2e[2]), .middle_mirror_rail_off_o(out_2e[1]), .negative_rail_off_o(out_2e[0]),
        .fuse_read_current_o(out_2f[6:5]), .fuse_write_current_o(out_2f[4:3]), .fuse_burn_pulse_length_o(out_2f[2:0]),
        .fuse_burn_enable_o(burn_en), .soft_reset_o(soft_rst), .first_alarm_status_o(al0_o),
        .second_alarm_status_o(al1_o));

    always #50 core_clk_i = ~core_clk_i;

    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reset_model();
        foreach (mdl[i]) mdl[i] = 0;
        mdl['h2c] = 'h30;
    endtask

    // ----
    // Bus master: hold until waitrequest low
    // ----
    task automatic bus(input logic wr, input logic [5:0] ofs, input logic [7:0] d, input logic be0,
                       output logic [31:0] rd);
        logic [31:0] rnd;
        int w;
        rnd = $random(seed);
        w = 0;
        avs_address_i <= {ofs, 2'b00};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= {rnd[31:8], d};
        avs_byteenable_i <= {rnd[3:1], be0};
        @(posedge core_clk_i);
        while (avs_waitrequest_o !== 1'b0 && w < 40) begin
            @(posedge core_clk_i);
            w++;
        end
        chk("bus_answer", {31'h0, avs_waitrequest_o}, 32'h0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [5:0] ofs, input logic [7:0] d, input logic be0);
        logic [31:0] rd;
        bus(1'b1, ofs, d, be0, rd);
        if (be0 && ((ofs >= 6'h2b && ofs <= 6'h2f) || ofs == 6'h3a || ofs == 6'h3b)) mdl[ofs] = d;
    endtask

    task automatic rd_chk(input logic [5:0] ofs);
        logic [31:0] rd;
        bus(1'b0, ofs, 8'h00, 1'b1, rd);
        chk("readdata", rd, mdl[ofs]);
    endtask

    task automatic out_chk();
        @(posedge core_clk_i);
        chk("drive_ctrl", out_2b, mdl['h2b]);
        chk("startup", out_2c, mdl['h2c][7:2]);
        chk("speedup", out_2d, mdl['h2d]);
        chk("rails", out_2e, mdl['h2e][2:0]);
        chk("fuse_setup", out_2f, mdl['h2f][6:0]);
    endtask

    initial begin
        #(100 * 20000);
        err_count++;
        finish_test();
    end

    initial begin
        reset_model();
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        foreach (regs[i]) rd_chk(regs[i]);
        out_chk();
        // ----
        // Field sweeps and random writes
        // ----
        for (k = 0; k < 8; k++) begin
            wr(6'h2f, {1'b0, k[1:0], k[1:0], k[2:0]}, 1'b1);
            wr(6'h2c, {k[1], k[0], k[1:0], k[2], k[0], 2'b00}, 1'b1);
            wr(6'h2b, {k[1:0], k[1:0], 4'b0001 << k[1:0]}, 1'b1);
            out_chk();
        end
        repeat (30) begin
            r = $random(seed);
            wr(wregs[r[10:8] % 7], r[7:0], r[12] | r[13]);
            out_chk();
            rd_chk(wregs[r[10:8] % 7]);
        end
        wr(6'h2c, 8'hff, 1'b0);
        wr(6'h20, 8'hff, 1'b1);
        out_chk();
        rd_chk(6'h20);
        // ----
        // Keyed soft reset
        // ----
        wr(6'h30, 8'h5a, 1'b1);
        out_chk();
        chk("soft_reset", soft_rst, 0);
        wr(6'h30, 8'haa, 1'b1);
        n = 0;
        while (soft_rst !== 1'b1 && n < 10) begin
            @(posedge core_clk_i);
            n++;
        end
        n = 0;
        while (soft_rst === 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            n++;
        end
        chk("soft_reset_cycles", n, 14);
        reset_model();
        out_chk();
        foreach (regs[i]) rd_chk(regs[i]);
        // ----
        // Fuse unlock sequence
        // ----
        fuse_burn_req_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        chk("burn_enable", burn_en, 0);
        wr(6'h31, 8'haf, 1'b1);
        wr(6'h32, 8'hfa, 1'b1);
        wr(6'h33, 8'h55, 1'b1);
        mdl['h3d] = 3;
        rd_chk(6'h3d);
        repeat (10) @(posedge core_clk_i);
        chk("burn_enable", burn_en, 1);
        fuse_burn_done_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        fuse_burn_done_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        chk("burn_enable", burn_en, 0);
        mdl['h3d] = 0;
        rd_chk(6'h3d);
        for (k = 0; k < 2; k++) begin
            wr(6'h31, 8'haf, 1'b1);
            if (k == 0) wr(6'h2b, 8'h11, 1'b1);
            wr(6'h32, (k == 0) ? 8'hfa : 8'h00, 1'b1);
            wr(6'h33, 8'h55, 1'b1);
            rd_chk(6'h3d);
            repeat (10) @(posedge core_clk_i);
            chk("burn_enable", burn_en, 0);
        end
        fuse_burn_req_i <= 1'b0;
        // ----
        // Alarm masking
        // ----
        repeat (4) begin
            r = $random(seed);
            r2 = $random(seed);
            wr(6'h3a, r[7:0], 1'b1);
            wr(6'h3b, r[15:8], 1'b1);
            first_alarm_status_i <= r2[7:0];
            second_alarm_status_i <= r2[15:8];
            repeat (8) @(posedge core_clk_i);
            chk("first_alarm", al0_o, r2[7:0] & ~r[7:0]);
            chk("second_alarm", al1_o, r2[15:8] & ~r[15:8]);
            mdl['h3c] = r2[7:0];
            rd_chk(6'h3c);
        end
        finish_test();
    end
endmodule // converter_fuse_reset_config_bank_test
`default_nettype wire
